// *** core/eth_port_stats.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "stats_consts.svh"

// Summary of operation
// - Every counter is readable by the host at its own fixed address.
// - A host read clears the counter read; counting restarts from zero.
// - Each port has its own full counter set; ports never interact.
// - Per direction, separate 32-bit good-octet and bad-octet counts.
// - Receive alignment and checksum errors counted apart; transmit CRC errors too.
// - Undersized receive frames split into fragment and undersize counters.
// - Single, multiple, late, total collisions; total leaves out late ones.
// - Overflow drop counters step on each receive or transmit FIFO overflow.
// - With filtering on, errored-drop counters also count filtered frames.
// - Good means error-free with length from 64 to 1518 inclusive.
// - Bad means CRC error, receive alignment error, under 64 or over 1518 octets.
// - Frames 1519 up to programmed maximum are jumbo, CRC-checked, binned.
module eth_port_stats
  import stats_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Host read port
  input wire logic cpu_rd,
  input wire logic [`ADDR_W-1:0] cpu_addr,
  output logic [`CNT_W-1:0] cpu_rdata,
  output logic cpu_rvalid,
  // Per-port frame and drop events
  input wire rx_frame_s [`PORT_NUM-1:0] rx_ev,
  input wire tx_frame_s [`PORT_NUM-1:0] tx_ev,
  input wire drop_s [`PORT_NUM-1:0] drop_ev,
  // Per-port settings
  input wire logic [`PORT_NUM-1:0] filter_en,
  input wire logic [`PORT_NUM-1:0][`INC_W-1:0] max_len
);

  logic rd_ok;
  logic [1:0] rd_port;
  logic [5:0] rd_idx;
  logic [6:0] offset;
  logic [`CNT_W-1:0] rd_sel;
  logic [`CNT_W-1:0] cnt_w [`PORT_NUM][`CNT_NUM];

  // Picks the length bin; jumbo only up to the port's programmed maximum
  function automatic logic [2:0] bin_of(input logic [`INC_W-1:0] len,
                                        input logic [`INC_W-1:0] maxl);
    logic [2:0] b;
    b = `NO_BIN;
    if (len < `MIN_LEN) b = `NO_BIN;
    else if (len == `MIN_LEN) b = 3'h0;
    else if (len <= `BIN1_MAX) b = 3'h1;
    else if (len <= `BIN2_MAX) b = 3'h2;
    else if (len <= `BIN3_MAX) b = 3'h3;
    else if (len <= `BIN4_MAX) b = 3'h4;
    else if (len <= `STD_MAX) b = 3'h5;
    else if (len <= maxl) b = `JUMBO_BIN;
    return b;
  endfunction

  assign offset = cpu_addr[6:0];

  // Address decode into port and counter index
  always_comb begin
    rd_ok = 1'b0;
    rd_port = 2'h0;
    rd_idx = 6'h00;
    if (cpu_addr[`ADDR_W-1:`PORT_MSB+1] == '0 &&
        offset >= `STAT_FIRST && offset <= `STAT_LAST) begin
      rd_ok = 1'b1;
      rd_port = cpu_addr[`PORT_MSB:`PORT_LSB];
      rd_idx = 6'(offset - `STAT_FIRST);
    end
    for (int p = 0; p < `PORT_NUM; p++) begin
      if (cpu_addr == 11'(`RX_OVF_BASE + p)) begin
        rd_ok = 1'b1;
        rd_port = 2'(p);
        rd_idx = CNT_RX_OVF_DROP;
      end
      if (cpu_addr == 11'(`RX_ERR_BASE + p)) begin
        rd_ok = 1'b1;
        rd_port = 2'(p);
        rd_idx = CNT_RX_ERR_DROP;
      end
      if (cpu_addr == 11'(`TX_OVF_BASE + p)) begin
        rd_ok = 1'b1;
        rd_port = 2'(p);
        rd_idx = CNT_TX_OVF_DROP;
      end
      if (cpu_addr == 11'(`TX_ERR_BASE + p)) begin
        rd_ok = 1'b1;
        rd_port = 2'(p);
        rd_idx = CNT_TX_ERR_DROP;
      end
    end
  end

  assign rd_sel = cnt_w[rd_port][rd_idx];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cpu_rvalid <= 1'b0;
    end else begin
      cpu_rvalid <= cpu_rd;
    end
  end

  // Unmapped addresses read as zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cpu_rdata <= '0;
    end else if (cpu_rd) begin
      cpu_rdata <= rd_ok ? rd_sel : '0;
    end
  end

  read_data_a:
    assert property (@(posedge clock) disable iff (rst)
      (cpu_rd && rd_ok) |=> cpu_rvalid && cpu_rdata == $past(rd_sel))
    else $error("read data is not the addressed counter");

  for (genvar p = 0; p < `PORT_NUM; p++) begin : g_port
    rx_frame_s rx;
    tx_frame_s tx;
    drop_s dr;
    inc_vec_t inc_v;
    logic rx_short, rx_std, rx_good, rx_long;
    logic tx_short, tx_std, tx_good;
    logic [2:0] rx_bin, tx_bin;

    assign rx = rx_ev[p];
    assign tx = tx_ev[p];
    assign dr = drop_ev[p];
    assign rx_short = rx.len < `MIN_LEN;
    assign rx_std = rx.len <= `STD_MAX;
    assign rx_long = rx.len > max_len[p];
    assign tx_short = tx.len < `MIN_LEN;
    assign tx_std = tx.len <= `STD_MAX;
    assign rx_good = !rx.crc_err && !rx.align_err && !rx_short && rx_std;
    assign tx_good = !tx.crc_err && !tx_short && tx_std;
    assign rx_bin = bin_of(rx.len, max_len[p]);
    assign tx_bin = bin_of(tx.len, max_len[p]);

    always_comb begin
      inc_v = '0;
      if (rx.valid) begin
        if (rx_good) begin
          inc_v[CNT_RX_GOOD_OCT] = rx.len;
          unique case (rx.cast)
            CAST_UNI: inc_v[CNT_RX_UNI] = `ONE;
            CAST_BROAD: inc_v[CNT_RX_BROAD] = `ONE;
            default: inc_v[CNT_RX_MULTI] = `ONE;
          endcase
        end else begin
          inc_v[CNT_RX_BAD_OCT] = rx.len;
        end
        if (rx.align_err) inc_v[CNT_RX_ALIGN] = `ONE;
        if (rx.crc_err) inc_v[CNT_RX_CHECKSUM] = `ONE;
        if (rx_short && rx.crc_err) inc_v[CNT_RX_FRAGMENT] = `ONE;
        if (rx_short && !rx.crc_err) inc_v[CNT_RX_UNDERSIZE] = `ONE;
        if (rx_long && !rx.crc_err) inc_v[CNT_RX_OVERSIZE] = `ONE;
        if (rx_long && rx.crc_err) inc_v[CNT_LONG_BAD] = `ONE;
        if (rx_bin != `NO_BIN) begin
          inc_v[6'(CNT_RX_BIN_MIN) + 6'(rx_bin)] = `ONE;
        end
      end
      if (tx.valid) begin
        if (tx_good) begin
          inc_v[CNT_TX_GOOD_OCT] = tx.len;
          unique case (tx.cast)
            CAST_UNI: inc_v[CNT_TX_UNI] = `ONE;
            CAST_BROAD: inc_v[CNT_TX_BROAD] = `ONE;
            default: inc_v[CNT_TX_MULTI] = `ONE;
          endcase
        end else begin
          inc_v[CNT_TX_BAD_OCT] = tx.len;
        end
        if (tx.crc_err) inc_v[CNT_TX_CHECKSUM] = `ONE;
        if (tx.len > max_len[p]) inc_v[CNT_TX_OVERSIZE_DROP] = `ONE;
        if (tx.late_col) begin
          inc_v[CNT_TX_LATE_COL] = `ONE;
        end else begin
          inc_v[CNT_TX_ALL_COL] = `INC_W'(tx.collisions);
          if (tx.collisions == `COL_ONE) inc_v[CNT_TX_ONE_COL] = `ONE;
          if (tx.collisions > `COL_ONE) inc_v[CNT_TX_MANY_COL] = `ONE;
        end
        if (tx_bin != `NO_BIN) begin
          inc_v[6'(CNT_TX_BIN_MIN) + 6'(tx_bin)] = `ONE;
        end
      end
      if (dr.rx_ovf) inc_v[CNT_RX_OVF_DROP] = `ONE;
      if (dr.tx_ovf) inc_v[CNT_TX_OVF_DROP] = `ONE;
      if (dr.rx_ovf || (filter_en[p] && dr.rx_filt)) begin
        inc_v[CNT_RX_ERR_DROP] = `ONE;
      end
      if (dr.tx_ovf || (filter_en[p] && dr.tx_filt)) begin
        inc_v[CNT_TX_ERR_DROP] = `ONE;
      end
    end

    for (genvar i = 0; i < `CNT_NUM; i++) begin : g_cnt
      logic hit;
      assign hit = cpu_rd && rd_ok && rd_port == 2'(p) && rd_idx == 6'(i);
      stat_counter u_cnt (
        .clock(clock),
        .rst(rst),
        .hit(hit),
        .inc(inc_v[i]),
        .cnt_q(cnt_w[p][i])
      );
    end

    good_octets_a:
      assert property (@(posedge clock) disable iff (rst)
        (rx.valid && !rx.crc_err && !rx.align_err &&
         rx.len >= `MIN_LEN && rx.len <= `STD_MAX) |->
          inc_v[CNT_RX_GOOD_OCT] == rx.len && inc_v[CNT_RX_BAD_OCT] == '0)
      else $error("good frame not counted as good octets");

    bad_octets_a:
      assert property (@(posedge clock) disable iff (rst)
        (tx.valid && (tx.crc_err || tx.len < `MIN_LEN ||
         tx.len > `STD_MAX)) |->
          inc_v[CNT_TX_BAD_OCT] == tx.len && inc_v[CNT_TX_GOOD_OCT] == '0)
      else $error("bad frame not counted as bad octets");

    align_crc_a:
      assert property (@(posedge clock) disable iff (rst)
        (rx.valid && rx.align_err && !rx.crc_err) |->
          inc_v[CNT_RX_ALIGN] == `ONE && inc_v[CNT_RX_CHECKSUM] == '0)
      else $error("alignment error miscounted");

    runt_split_a:
      assert property (@(posedge clock) disable iff (rst)
        (rx.valid && rx.len < `MIN_LEN) |->
          (inc_v[CNT_RX_FRAGMENT] + inc_v[CNT_RX_UNDERSIZE]) == `ONE)
      else $error("undersized frame not counted exactly once");

    late_excluded_a:
      assert property (@(posedge clock) disable iff (rst)
        (tx.valid && tx.late_col) |->
          inc_v[CNT_TX_ALL_COL] == '0 && inc_v[CNT_TX_LATE_COL] == `ONE)
      else $error("late collision leaked into total");

    overflow_drop_a:
      assert property (@(posedge clock) disable iff (rst)
        dr.rx_ovf |-> inc_v[CNT_RX_OVF_DROP] == `ONE &&
          inc_v[CNT_RX_ERR_DROP] == `ONE)
      else $error("receive overflow not counted");

    filter_drop_a:
      assert property (@(posedge clock) disable iff (rst)
        (!dr.tx_ovf && dr.tx_filt) |->
          inc_v[CNT_TX_ERR_DROP] == (filter_en[p] ? `ONE : '0))
      else $error("filtered transmit frame miscounted");

    jumbo_bin_a:
      assert property (@(posedge clock) disable iff (rst)
        (rx.valid && rx.len > `STD_MAX && rx.len <= max_len[p]) |->
          inc_v[CNT_RX_BIN_JUMBO] == `ONE && inc_v[CNT_RX_OVERSIZE] == '0)
      else $error("jumbo frame not binned");

    min_bin_a:
      assert property (@(posedge clock) disable iff (rst)
        (tx.valid && tx.len == `MIN_LEN) |->
          inc_v[CNT_TX_BIN_MIN] == `ONE && inc_v[CNT_TX_BIN_127] == '0)
      else $error("minimum length frame not binned");
  end

endmodule // eth_port_stats

`default_nettype wire

// *** core/stats_consts.svh ***
`ifndef STATS_CONSTS_SVH
`define STATS_CONSTS_SVH

// Sizes
`define PORT_NUM 4
`define CNT_NUM 40
`define CNT_W 32
`define INC_W 14
`define ADDR_W 11

// Host address map: port block in addr[8:7], counter offset in addr[6:0]
`define PORT_LSB 7
`define PORT_MSB 8
`define STAT_FIRST 7'h20
`define STAT_LAST 7'h43
`define RX_OVF_BASE 11'h594
`define RX_ERR_BASE 11'h5a2
`define TX_OVF_BASE 11'h621
`define TX_ERR_BASE 11'h625

// Frame length limits and bin edges
`define MIN_LEN 14'h040
`define BIN1_MAX 14'h07f
`define BIN2_MAX 14'h0ff
`define BIN3_MAX 14'h1ff
`define BIN4_MAX 14'h3ff
`define STD_MAX 14'h5ee
`define JUMBO_BIN 3'h6
`define NO_BIN 3'h7

// Increment amounts
`define ONE 14'h001
`define COL_ONE 4'h1

`endif

// *** core/stats_pkg.sv ***
`include "stats_consts.svh"

package stats_pkg;

  typedef enum logic [1:0] {
    CAST_UNI = 2'b00,
    CAST_BROAD = 2'b01,
    CAST_MULTI = 2'b10
  } cast_e;

  typedef enum logic [5:0] {
    CNT_RX_GOOD_OCT, CNT_RX_BAD_OCT, CNT_TX_GOOD_OCT, CNT_TX_BAD_OCT,
    CNT_RX_UNI, CNT_RX_BROAD, CNT_RX_MULTI,
    CNT_TX_UNI, CNT_TX_BROAD, CNT_TX_MULTI,
    CNT_RX_ALIGN, CNT_RX_CHECKSUM, CNT_TX_CHECKSUM,
    CNT_RX_FRAGMENT, CNT_RX_UNDERSIZE, CNT_RX_OVERSIZE,
    CNT_TX_OVERSIZE_DROP, CNT_LONG_BAD,
    CNT_TX_ONE_COL, CNT_TX_MANY_COL, CNT_TX_LATE_COL, CNT_TX_ALL_COL,
    CNT_RX_BIN_MIN, CNT_RX_BIN_127, CNT_RX_BIN_255, CNT_RX_BIN_511,
    CNT_RX_BIN_1023, CNT_RX_BIN_1518, CNT_RX_BIN_JUMBO,
    CNT_TX_BIN_MIN, CNT_TX_BIN_127, CNT_TX_BIN_255, CNT_TX_BIN_511,
    CNT_TX_BIN_1023, CNT_TX_BIN_1518, CNT_TX_BIN_JUMBO,
    CNT_RX_OVF_DROP, CNT_RX_ERR_DROP, CNT_TX_OVF_DROP, CNT_TX_ERR_DROP
  } cnt_e;

  // End-of-frame report for a received frame
  typedef struct packed {
    logic valid;
    logic [`INC_W-1:0] len;
    logic crc_err;
    logic align_err;
    cast_e cast;
  } rx_frame_s;

  // End-of-frame report for a transmitted frame
  typedef struct packed {
    logic valid;
    logic [`INC_W-1:0] len;
    logic crc_err;
    cast_e cast;
    logic [3:0] collisions;
    logic late_col;
  } tx_frame_s;

  // FIFO overflow and filter removal pulses
  typedef struct packed {
    logic rx_ovf;
    logic rx_filt;
    logic tx_ovf;
    logic tx_filt;
  } drop_s;

  typedef logic [`CNT_NUM-1:0][`INC_W-1:0] inc_vec_t;

endpackage

// *** core/stat_counter.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "stats_consts.svh"

module stat_counter (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Update
  input wire logic hit,
  input wire logic [`INC_W-1:0] inc,
  // Count
  output logic [`CNT_W-1:0] cnt_q
);

  logic [`CNT_W:0] sum;
  logic [`CNT_W-1:0] inc_w;

  assign inc_w = `CNT_W'(inc);
  assign sum = {1'b0, cnt_q} + (`CNT_W+1)'(inc);

  // A read clears, but an event in the same cycle survives the clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (hit) begin
      cnt_q <= inc_w;
    end else if (sum[`CNT_W]) begin
      cnt_q <= '1;
    end else begin
      cnt_q <= sum[`CNT_W-1:0];
    end
  end

  clear_on_read_a:
    assert property (@(posedge clock) disable iff (rst)
      hit |=> cnt_q == $past(inc_w))
    else $error("counter not cleared to the coincident event on read");

  saturate_hold_a:
    assert property (@(posedge clock) disable iff (rst)
      (!hit && (&cnt_q)) |=> (&cnt_q))
    else $error("saturated counter wrapped");

  idle_hold_a:
    assert property (@(posedge clock) disable iff (rst)
      (!hit && inc == '0) |=> $stable(cnt_q))
    else $error("counter changed with no event and no read");

  accumulate_a:
    assert property (@(posedge clock) disable iff (rst)
      (!hit && !sum[`CNT_W]) |=>
        cnt_q == $past(cnt_q) + $past(inc_w))
    else $error("counter did not add its increment");

endmodule // stat_counter

`default_nettype wire

// *** tb/eth_port_stats_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "stats_consts.svh"

module eth_port_stats_bench;
  import stats_pkg::*;

  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cpu_rd = 1'b0;
  logic [`ADDR_W-1:0] cpu_addr = '0;
  logic [`CNT_W-1:0] cpu_rdata;
  logic cpu_rvalid;
  rx_frame_s [`PORT_NUM-1:0] rx_ev = '0;
  tx_frame_s [`PORT_NUM-1:0] tx_ev = '0;
  drop_s [`PORT_NUM-1:0] drop_ev = '0;
  logic [`PORT_NUM-1:0] filter_en = '0;
  logic [`PORT_NUM-1:0][`INC_W-1:0] max_len = {`PORT_NUM{14'h07d0}};
  int n_fail = 0;
  int checked = 0;

  always #5 clock = ~clock;

  eth_port_stats u_eth_port_stats (
    .clock(clock),
    .rst(rst),
    .cpu_rd(cpu_rd),
    .cpu_addr(cpu_addr),
    .cpu_rdata(cpu_rdata),
    .cpu_rvalid(cpu_rvalid),
    .rx_ev(rx_ev),
    .tx_ev(tx_ev),
    .drop_ev(drop_ev),
    .filter_en(filter_en),
    .max_len(max_len)
  );

  task automatic results;
    $display("checked %0d, failed %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %0t read %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [10:0] ca(input int p, input cnt_e c);
    return 11'(p * 128 + 32 + int'(c));
  endfunction

  // Read strobe raised on a falling edge; answer is due one cycle later
  task automatic rd(input logic [10:0] a, output logic [31:0] d);
    int k;
    cpu_rd = 1'b1;
    cpu_addr = a;
    @(negedge clock);
    cpu_rd = 1'b0;
    k = 0;
    while (cpu_rvalid !== 1'b1 && k < 4) begin
      @(negedge clock);
      k++;
    end
    if (cpu_rvalid !== 1'b1) begin
      n_fail++;
      $display("FAIL %0t no read answer", $time);
      results();
    end else begin
      d = cpu_rdata;
      // Idle cycle so the next strobe starts from a low level
      @(negedge clock);
    end
  endtask

  task automatic chkr(input logic [10:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(d, exp);
  endtask

  task automatic rxf(input int p, input logic [13:0] len, input logic crc,
                     input logic al, input cast_e c);
    rx_ev[p] = '{valid: 1'b1, len: len, crc_err: crc, align_err: al, cast: c};
    @(negedge clock);
    rx_ev[p] = '0;
    @(negedge clock);
  endtask

  task automatic txf(input int p, input logic [13:0] n,
                     input logic [3:0] col, input logic late,
                     input logic crc);
    tx_ev[p] = '{valid: 1'b1, len: n, crc_err: crc, cast: CAST_UNI,
                 collisions: col, late_col: late};
    @(negedge clock);
    tx_ev[p] = '0;
    @(negedge clock);
  endtask

  task automatic dp(input int p, input drop_s d);
    drop_ev[p] = d;
    @(negedge clock);
    drop_ev[p] = '0;
    @(negedge clock);
  endtask

  initial begin
    repeat (10) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    chkr(ca(0, CNT_RX_GOOD_OCT), 32'h0);
    $display("test reset done");

    rxf(0, 14'h0064, 1'b0, 1'b0, CAST_UNI);
    chkr(ca(0, CNT_RX_GOOD_OCT), 32'h64);
    chkr(ca(0, CNT_RX_GOOD_OCT), 32'h0);
    chkr(ca(0, CNT_RX_UNI), 32'h1);
    chkr(ca(1, CNT_RX_GOOD_OCT), 32'h0);
    chkr(ca(1, CNT_RX_UNI), 32'h0);
    // Read and event on the same edge: old value out, event kept
    rxf(0, 14'h0064, 1'b0, 1'b0, CAST_UNI);
    rx_ev[0] = '{valid: 1'b1, len: 14'h00c8, crc_err: 1'b0, align_err: 1'b0,
                 cast: CAST_UNI};
    cpu_addr = ca(0, CNT_RX_GOOD_OCT);
    cpu_rd = 1'b1;
    @(negedge clock);
    rx_ev[0] = '0;
    cpu_rd = 1'b0;
    check(32'(cpu_rvalid), 32'h1);
    check(cpu_rdata, 32'h64);
    @(negedge clock);
    chkr(ca(0, CNT_RX_GOOD_OCT), 32'hc8);
    chkr(11'h7ff, 32'h0);
    $display("test read clear done");

    rxf(2, 14'h0040, 1'b0, 1'b0, CAST_UNI);
    rxf(2, 14'h05ee, 1'b0, 1'b0, CAST_BROAD);
    rxf(2, 14'h003f, 1'b0, 1'b0, CAST_UNI);
    rxf(2, 14'h003f, 1'b1, 1'b0, CAST_UNI);
    rxf(2, 14'h05ef, 1'b0, 1'b0, CAST_UNI);
    rxf(2, 14'h0064, 1'b0, 1'b1, CAST_MULTI);
    chkr(ca(2, CNT_RX_GOOD_OCT), 32'h62e);
    chkr(ca(2, CNT_RX_BAD_OCT), 32'h6d1);
    chkr(ca(2, CNT_RX_UNI), 32'h1);
    chkr(ca(2, CNT_RX_BROAD), 32'h1);
    chkr(ca(2, CNT_RX_MULTI), 32'h0);
    chkr(ca(2, CNT_RX_ALIGN), 32'h1);
    chkr(ca(2, CNT_RX_FRAGMENT), 32'h1);
    chkr(ca(2, CNT_RX_UNDERSIZE), 32'h1);
    chkr(ca(2, CNT_RX_BIN_MIN), 32'h1);
    chkr(ca(2, CNT_RX_BIN_127), 32'h1);
    chkr(ca(2, CNT_RX_BIN_1518), 32'h1);
    chkr(ca(2, CNT_RX_BIN_JUMBO), 32'h1);
    rxf(3, 14'h0064, 1'b1, 1'b0, CAST_UNI);
    chkr(ca(3, CNT_RX_CHECKSUM), 32'h1);
    chkr(ca(3, CNT_RX_ALIGN), 32'h0);
    $display("test receive classes done");

    txf(1, 14'h0064, 4'h1, 1'b0, 1'b0);
    txf(1, 14'h0064, 4'h3, 1'b0, 1'b0);
    txf(1, 14'h0064, 4'h0, 1'b1, 1'b0);
    txf(1, 14'h0064, 4'h0, 1'b0, 1'b1);
    chkr(ca(1, CNT_TX_GOOD_OCT), 32'h12c);
    chkr(ca(1, CNT_TX_BAD_OCT), 32'h64);
    chkr(ca(1, CNT_TX_CHECKSUM), 32'h1);
    chkr(ca(1, CNT_TX_ONE_COL), 32'h1);
    chkr(ca(1, CNT_TX_MANY_COL), 32'h1);
    chkr(ca(1, CNT_TX_LATE_COL), 32'h1);
    chkr(ca(1, CNT_TX_ALL_COL), 32'h4);
    $display("test transmit done");

    dp(3, '{rx_ovf: 1'b1, rx_filt: 1'b0, tx_ovf: 1'b1, tx_filt: 1'b0});
    dp(3, '{rx_ovf: 1'b0, rx_filt: 1'b1, tx_ovf: 1'b0, tx_filt: 1'b1});
    filter_en[3] = 1'b1;
    dp(3, '{rx_ovf: 1'b0, rx_filt: 1'b1, tx_ovf: 1'b0, tx_filt: 1'b1});
    dp(3, '{rx_ovf: 1'b1, rx_filt: 1'b1, tx_ovf: 1'b0, tx_filt: 1'b0});
    chkr(`RX_OVF_BASE + 11'h3, 32'h2);
    chkr(`RX_ERR_BASE + 11'h3, 32'h3);
    chkr(`TX_OVF_BASE + 11'h3, 32'h1);
    chkr(`TX_ERR_BASE + 11'h3, 32'h2);
    chkr(`RX_OVF_BASE + 11'h3, 32'h0);
    chkr(`RX_OVF_BASE + 11'h2, 32'h0);
    $display("test drops done");

    max_len[1] = 14'h0600;
    rxf(1, 14'h0601, 1'b0, 1'b0, CAST_MULTI);
    rxf(1, 14'h0601, 1'b1, 1'b0, CAST_UNI);
    rxf(1, 14'h0600, 1'b0, 1'b0, CAST_UNI);
    rxf(1, 14'h0080, 1'b0, 1'b0, CAST_MULTI);
    txf(1, 14'h0601, 4'h0, 1'b0, 1'b0);
    txf(1, 14'h0200, 4'h0, 1'b0, 1'b0);
    chkr(ca(1, CNT_RX_BAD_OCT), 32'h1202);
    chkr(ca(1, CNT_RX_OVERSIZE), 32'h1);
    chkr(ca(1, CNT_LONG_BAD), 32'h1);
    chkr(ca(1, CNT_RX_CHECKSUM), 32'h1);
    chkr(ca(1, CNT_RX_BIN_JUMBO), 32'h1);
    chkr(ca(1, CNT_RX_MULTI), 32'h1);
    chkr(ca(1, CNT_RX_BIN_255), 32'h1);
    chkr(ca(1, CNT_TX_OVERSIZE_DROP), 32'h1);
    chkr(ca(1, CNT_TX_BAD_OCT), 32'h601);
    chkr(ca(1, CNT_TX_BIN_1023), 32'h1);
    chkr(ca(1, CNT_TX_UNI), 32'h4);
    $display("test size limits done");
    results();
  end
endmodule // eth_port_stats_bench

`default_nettype wire
